// ### common/sar_pkg.sv
package sar_pkg;
   // ****************************************
   // sizes of the data structures
   // ****************************************
   localparam int CM_AW = 16;          // control memory word address width
   localparam int HA_W = 17;           // link register address; top bit picks control memory
   localparam int CH_W = 15;           // channel number width
   localparam int REG_AW = 4;
   localparam int REG_CNT = 16;
   localparam int TX_CH_MAX = 1023;
   localparam int RX_ST_MAX = 30720;
   localparam int SEG_RING_MAX = 256;
   localparam int FB_RING_CNT = 256;
   localparam int SCHED_WORDS = 3100;
   localparam int SCHED_ENT_W = 16;
   localparam int SCHED_RES_KBPS = 32;

   // ****************************************
   // control memory layout, word indices
   // ****************************************
   localparam int CM_SCHED = 'h0000;
   localparam int CM_TX_ST = 'h1000;
   localparam int CM_RPT = 'h3000;
   localparam int CM_PTR = 'h3400;
   localparam int TX_ST_WORDS = 8;
   localparam int TXW_FLAGS = 0;
   localparam int TXW_SEG_BASE = 1;
   localparam int TXW_SEG_IDX = 2;
   localparam int RXW_FLAGS = 0;
   localparam int RXW_FB = 6;
   localparam int RPT_WORDS = 4;
   localparam int RPW_BASE = 0;
   localparam int RPW_BUF_SZ = 1;
   localparam int RPW_RING_SZ = 2;
   localparam int RPW_CUR = 3;
   localparam int F_INT = 0;           // flags bit: completions go to interrupting ring
   localparam int F_FIFO = 1;          // flags bit: free buffers come from a fifo

   // ****************************************
   // device register indices and resets
   // ****************************************
   localparam int R_CFG = 0;
   localparam int R_STAT = 1;
   localparam int R_CSIZE0 = 2;        // 2..5, one per completion ring
   localparam int R_CBASE0 = 6;        // 6..9, one per completion ring
   localparam int R_SEG_SIZE = 10;
   localparam int R_FIFO_SZ = 11;
   localparam int R_SCHED_SZ = 12;
   localparam int R_POST_CNT = 13;
   localparam int R_AGE = 14;
   localparam int R_MASK = 15;
   localparam logic [31:0] CSIZE_RST = 32'h0000_0100;
   localparam logic [31:0] SEG_SIZE_RST = 32'h0000_0100;
   localparam logic [31:0] MASK_RST = 32'h0000_000f;
   localparam logic [1:0] RING_TX_INT = 2'h0;
   localparam logic [1:0] RING_TX_NOINT = 2'h1;
   localparam logic [1:0] RING_RX_INT = 2'h2;
   localparam logic [1:0] RING_RX_NOINT = 2'h3;

   // ****************************************
   // host controller apb map
   // ****************************************
   localparam logic [11:0] A_CMD = 12'h000;
   localparam logic [11:0] A_ADDR = 12'h004;
   localparam logic [11:0] A_WDATA = 12'h008;
   localparam logic [11:0] A_RDATA = 12'h00c;
   localparam logic [11:0] A_STAT = 12'h010;
   localparam logic [1:0] A_MEM_SEL = 2'h1;   // paddr[11:10], window at 0x400
   localparam int HM_AW = 8;

   typedef enum logic [1:0] {
      OP_TXQ = 2'h0,                   // fetch next packet from a segmentation ring
      OP_TXC = 2'h1,                   // post a transmit completion
      OP_RXB = 2'h2,                   // fetch a free buffer
      OP_RXC = 2'h3                    // post a receive completion
   } op_e;
endpackage

// ### common/sar_link_if.sv
`timescale 1ns/10ps
interface sar_link_if;
   // register and control memory access, host to device
   logic hreq;
   logic hwe;
   logic [sar_pkg::HA_W-1:0] haddr;
   logic [31:0] hwdata;
   logic hack;
   logic [31:0] hrdata;
   // host memory access, device to host
   logic mreq;
   logic mwe;
   logic [31:0] maddr;
   logic [31:0] mwdata;
   logic mack;
   logic [31:0] mrdata;
   // interrupt pulse
   logic irq;

   modport dev (input hreq, hwe, haddr, hwdata, output hack, hrdata,
                output mreq, mwe, maddr, mwdata, input mack, mrdata, output irq);
   modport host (output hreq, hwe, haddr, hwdata, input hack, hrdata,
                 input mreq, mwe, maddr, mwdata, output mack, mrdata, input irq);
endinterface

// ### rtl/sar_dev.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module sar_dev (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // link to the host
   sar_link_if.dev lnk,
   // operation request
   input wire logic op_valid,
   input wire sar_pkg::op_e op_code,
   input wire logic [sar_pkg::CH_W-1:0] op_chan,
   input wire logic [31:0] op_addr,
   // operation result
   output logic op_ready,
   output logic res_valid,
   output logic [31:0] res_addr,
   output logic [15:0] res_size
);
   localparam int AW = sar_pkg::CM_AW;
   localparam int TOP = sar_pkg::HA_W - 1;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_MEM = 2'b10} st_e;

   logic [31:0] cm [2**AW];
   logic [31:0] rf [sar_pkg::REG_CNT];
   logic [15:0] cidx_r [4];
   logic [31:0] post_cnt_r;
   st_e st_r;
   logic [1:0] ring_r, ring_nxt;
   logic wb_en_r, wb_en_nxt;
   logic [AW-1:0] wb_a_r, wb_a_nxt;
   logic [15:0] wb_v_r, wb_v_nxt;
   logic [31:0] ma_nxt;
   logic mwe_nxt;
   logic [15:0] size_nxt;
   logic [AW-1:0] tx_e, rx_e, rp_e;
   logic [31:0] tx_flags, seg_base, rx_flags, rx_fb, rp_base, rp_bsz, rp_rsz;
   logic [15:0] seg_idx, rp_cur;
   logic mem_done, post, h_new;
   logic [sar_pkg::REG_AW-1:0] h_idx;

   // ******************************************
   // helpers
   // ******************************************
   // next slot of a ring, back to slot 0 after the last
   function automatic logic [15:0] wrap_inc(input logic [15:0] idx, input logic [15:0] len);
      logic [15:0] n;
      n = idx + 16'h0001;
      wrap_inc = (n >= len) ? 16'h0000 : n;
   endfunction

   // byte address of a one-word ring slot
   function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [15:0] idx);
      slot_addr = base + {14'h0000, idx, 2'b00};
   endfunction

   // ******************************************
   // structure lookup
   // ******************************************
   // all control memory reads are combinational so a request is taken in the cycle it is seen, with no setup cycle
   always_comb begin
      tx_e = AW'(sar_pkg::CM_TX_ST + int'(op_chan) * sar_pkg::TX_ST_WORDS);
      tx_flags = cm[tx_e + AW'(sar_pkg::TXW_FLAGS)];
      seg_base = cm[tx_e + AW'(sar_pkg::TXW_SEG_BASE)];
      seg_idx = cm[tx_e + AW'(sar_pkg::TXW_SEG_IDX)][15:0];
      rx_e = cm[AW'(sar_pkg::CM_PTR + int'(op_chan))][AW-1:0];
      rx_flags = cm[rx_e + AW'(sar_pkg::RXW_FLAGS)];
      rx_fb = cm[rx_e + AW'(sar_pkg::RXW_FB)];
      rp_e = AW'(sar_pkg::CM_RPT + int'(rx_fb[7:0]) * sar_pkg::RPT_WORDS);
      rp_base = cm[rp_e + AW'(sar_pkg::RPW_BASE)];
      rp_bsz = cm[rp_e + AW'(sar_pkg::RPW_BUF_SZ)];
      rp_rsz = cm[rp_e + AW'(sar_pkg::RPW_RING_SZ)];
      rp_cur = cm[rp_e + AW'(sar_pkg::RPW_CUR)][15:0];
   end

   // what the pending operation will read or write
   always_comb begin
      ring_nxt = sar_pkg::RING_TX_INT;
      wb_en_nxt = 1'b0;
      wb_a_nxt = tx_e + AW'(sar_pkg::TXW_SEG_IDX);
      wb_v_nxt = wrap_inc(seg_idx, rf[sar_pkg::R_SEG_SIZE][15:0]);
      ma_nxt = slot_addr(seg_base, seg_idx);
      mwe_nxt = 1'b0;
      size_nxt = rf[sar_pkg::R_FIFO_SZ][15:0];
      unique case (op_code)
         sar_pkg::OP_TXQ: begin
            wb_en_nxt = 1'b1;
         end
         sar_pkg::OP_TXC: begin
            ring_nxt = tx_flags[sar_pkg::F_INT] ? sar_pkg::RING_TX_INT
                                                : sar_pkg::RING_TX_NOINT;
            mwe_nxt = 1'b1;
         end
         sar_pkg::OP_RXB: begin
            if (rx_flags[sar_pkg::F_FIFO]) begin
               ma_nxt = rx_fb;
            end else begin
               ma_nxt = slot_addr(rp_base, rp_cur);
               wb_en_nxt = 1'b1;
               wb_a_nxt = rp_e + AW'(sar_pkg::RPW_CUR);
               wb_v_nxt = wrap_inc(rp_cur, rp_rsz[15:0]);
               size_nxt = rp_bsz[15:0];
            end
         end
         sar_pkg::OP_RXC: begin
            ring_nxt = rx_flags[sar_pkg::F_INT] ? sar_pkg::RING_RX_INT
                                                : sar_pkg::RING_RX_NOINT;
            mwe_nxt = 1'b1;
         end
      endcase
      if (mwe_nxt) begin
         ma_nxt = slot_addr(rf[sar_pkg::R_CBASE0 + int'(ring_nxt)], cidx_r[ring_nxt]);
      end
   end

   assign mem_done = (st_r == ST_MEM) && lnk.mack;
   assign post = mem_done && lnk.mwe;
   assign h_new = lnk.hreq && !lnk.hack;
   assign h_idx = lnk.haddr[sar_pkg::REG_AW-1:0];

   // ******************************************
   // operation sequencer
   // ******************************************
   // one host memory access in flight at most; no data is staged on chip
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         op_ready <= 1'b1;
         res_valid <= 1'b0;
         res_addr <= 32'h0000_0000;
         res_size <= 16'h0000;
         lnk.mreq <= 1'b0;
         lnk.mwe <= 1'b0;
         lnk.maddr <= 32'h0000_0000;
         lnk.mwdata <= 32'h0000_0000;
         lnk.irq <= 1'b0;
         ring_r <= 2'h0;
         wb_en_r <= 1'b0;
         wb_a_r <= '0;
         wb_v_r <= 16'h0000;
      end else if (ce) begin
         res_valid <= 1'b0;
         lnk.irq <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               if (op_valid) begin
                  lnk.mreq <= 1'b1;
                  lnk.mwe <= mwe_nxt;
                  lnk.maddr <= ma_nxt;
                  lnk.mwdata <= op_addr;
                  ring_r <= ring_nxt;
                  wb_en_r <= wb_en_nxt;
                  wb_a_r <= wb_a_nxt;
                  wb_v_r <= wb_v_nxt;
                  res_size <= size_nxt;
                  op_ready <= 1'b0;
                  st_r <= ST_MEM;
               end
            end
            ST_MEM: begin
               if (lnk.mack) begin
                  lnk.mreq <= 1'b0;
                  op_ready <= 1'b1;
                  res_valid <= 1'b1;
                  res_addr <= lnk.mwe ? lnk.mwdata : lnk.mrdata;
                  // interrupting rings have an even id
                  lnk.irq <= lnk.mwe && !ring_r[0] && rf[sar_pkg::R_MASK][ring_r];
                  st_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // completion ring indices and posting statistic
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int r = 0; r < 4; r++) begin
            cidx_r[r] <= 16'h0000;
         end
         post_cnt_r <= 32'h0000_0000;
      end else if (ce && post) begin
         cidx_r[ring_r] <= wrap_inc(cidx_r[ring_r], rf[sar_pkg::R_CSIZE0 + int'(ring_r)][15:0]);
         post_cnt_r <= post_cnt_r + 32'h0000_0001;
      end
   end

   // ******************************************
   // control memory
   // ******************************************
   // host writes and index write-back may coincide; they hit different words in practice
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (h_new && lnk.hwe && lnk.haddr[TOP]) begin
            cm[lnk.haddr[AW-1:0]] <= lnk.hwdata;
         end
         if (mem_done && wb_en_r) begin
            cm[wb_a_r] <= {16'h0000, wb_v_r};
         end
      end
   end

   // ******************************************
   // register access from the host
   // ******************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < sar_pkg::REG_CNT; i++) begin
            rf[i] <= 32'h0000_0000;
         end
         for (int r = 0; r < 4; r++) begin
            rf[sar_pkg::R_CSIZE0 + r] <= sar_pkg::CSIZE_RST;
         end
         rf[sar_pkg::R_SEG_SIZE] <= sar_pkg::SEG_SIZE_RST;
         rf[sar_pkg::R_MASK] <= sar_pkg::MASK_RST;
         lnk.hack <= 1'b0;
         lnk.hrdata <= 32'h0000_0000;
      end else if (ce) begin
         lnk.hack <= h_new;
         if (h_new) begin
            // status and statistics words are read only
            if (lnk.hwe && !lnk.haddr[TOP] && h_idx != sar_pkg::REG_AW'(sar_pkg::R_STAT)
                && h_idx != sar_pkg::REG_AW'(sar_pkg::R_POST_CNT)) begin
               rf[h_idx] <= lnk.hwdata;
            end
            if (lnk.haddr[TOP]) begin
               lnk.hrdata <= cm[lnk.haddr[AW-1:0]];
            end else if (h_idx == sar_pkg::REG_AW'(sar_pkg::R_STAT)) begin
               lnk.hrdata <= {30'h0000_0000, st_r == ST_MEM, op_ready};
            end else if (h_idx == sar_pkg::REG_AW'(sar_pkg::R_POST_CNT)) begin
               lnk.hrdata <= post_cnt_r;
            end else begin
               lnk.hrdata <= rf[h_idx];
            end
         end
      end
   end
endmodule

// ### rtl/sar_host.sv
`timescale 1ns/10ps
module sar_host (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link to the device
   sar_link_if.host lnk
);
   localparam int HW = sar_pkg::HM_AW;

   logic [31:0] hmem [2**HW];
   logic [sar_pkg::HA_W-1:0] addr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [15:0] irq_cnt_r;
   logic apb_setup, apb_acc, apb_wr, mem_hit, apb_mwr, mem_srv, mapped;
   logic [31:0] rd_val;

   assign apb_setup = psel && !penable;
   assign apb_acc = psel && penable && pready;
   assign apb_wr = apb_acc && pwrite;
   assign mem_hit = paddr[11:10] == sar_pkg::A_MEM_SEL;
   assign apb_mwr = apb_wr && mem_hit;
   // device access waits one cycle when software writes host memory at the same edge
   assign mem_srv = lnk.mreq && !lnk.mack && !apb_mwr;

   // ******************************************
   // apb read decode
   // ******************************************
   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      if (mem_hit) begin
         rd_val = hmem[paddr[HW+1:2]];
      end else begin
         unique case (paddr)
            sar_pkg::A_CMD: rd_val = {31'h0000_0000, lnk.hreq};
            sar_pkg::A_ADDR: rd_val = 32'(addr_r);
            sar_pkg::A_WDATA: rd_val = wdata_r;
            sar_pkg::A_RDATA: rd_val = rdata_r;
            sar_pkg::A_STAT: rd_val = {irq_cnt_r, 15'h0000, lnk.hreq};
            default: mapped = 1'b0;
         endcase
      end
   end

   // answer every access after exactly one access-phase cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= apb_setup;
         if (apb_setup) begin
            prdata <= rd_val;
            pslverr <= !mapped;
         end
      end
   end

   // ******************************************
   // device command engine
   // ******************************************
   // ring selection bits and ring sizes reach the device through these writes
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         addr_r <= '0;
         wdata_r <= 32'h0000_0000;
         rdata_r <= 32'h0000_0000;
         lnk.hreq <= 1'b0;
         lnk.hwe <= 1'b0;
         lnk.haddr <= '0;
         lnk.hwdata <= 32'h0000_0000;
      end else if (ce) begin
         if (apb_wr && paddr == sar_pkg::A_ADDR) begin
            addr_r <= pwdata[sar_pkg::HA_W-1:0];
         end
         if (apb_wr && paddr == sar_pkg::A_WDATA) begin
            wdata_r <= pwdata;
         end
         // a command issued while one is pending is dropped
         if (apb_wr && paddr == sar_pkg::A_CMD && pwdata[0] && !lnk.hreq) begin
            lnk.hreq <= 1'b1;
            lnk.hwe <= pwdata[1];
            lnk.haddr <= addr_r;
            lnk.hwdata <= wdata_r;
         end else if (lnk.hack) begin
            lnk.hreq <= 1'b0;
            rdata_r <= lnk.hrdata;
         end
      end
   end

   // count interrupt pulses from the device
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_cnt_r <= 16'h0000;
      end else if (ce && lnk.irq) begin
         irq_cnt_r <= irq_cnt_r + 16'h0001;
      end
   end

   // ******************************************
   // host memory
   // ******************************************
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (apb_mwr) begin
            hmem[paddr[HW+1:2]] <= pwdata;
         end
         if (mem_srv && lnk.mwe) begin
            hmem[lnk.maddr[HW+1:2]] <= lnk.mwdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lnk.mack <= 1'b0;
         lnk.mrdata <= 32'h0000_0000;
      end else if (ce) begin
         lnk.mack <= mem_srv;
         if (mem_srv) begin
            lnk.mrdata <= hmem[lnk.maddr[HW+1:2]];
         end
      end
   end
endmodule

// ### tb/sar_link_props.sv
`timescale 1ns/10ps
module sar_link_props (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register channel
   input wire logic hreq,
   input wire logic hwe,
   input wire logic [sar_pkg::HA_W-1:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic hack,
   // memory channel and interrupt
   input wire logic mreq,
   input wire logic mwe,
   input wire logic [31:0] maddr,
   input wire logic [31:0] mwdata,
   input wire logic mack,
   input wire logic irq
);
   // ****************************************
   // link protocol checks, one clock domain
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_hack_one_cycle: assert property (hreq && !hack |=> hack)
      else $error("register ack not one cycle after request");
   chk_hack_pulse: assert property (hack |=> !hack)
      else $error("register ack longer than one cycle");
   chk_hreq_held: assert property (
      hreq && !hack |=> hreq && $stable(haddr) && $stable(hwdata))
      else $error("register request changed before ack");
   chk_mreq_held: assert property (
      mreq && !mack |=> mreq && $stable(maddr) && $stable(mwe))
      else $error("memory request changed before ack");
   chk_mack_bound: assert property ($rose(mreq) |-> ##[1:2] mack)
      else $error("memory ack late");
   chk_mreq_drop: assert property (mreq && mack |=> !mreq)
      else $error("memory request held after ack");
   chk_irq_after_post: assert property (irq |-> $past(mack && mwe && mreq))
      else $error("interrupt without a posted entry");
   chk_irq_pulse: assert property (irq |=> !irq)
      else $error("interrupt longer than one cycle");
   chk_slot_aligned: assert property (mreq |-> maddr[1:0] == 2'h0)
      else $error("ring slot address not word aligned");

   // main traffic kinds
   cov_reg_write: cover property (hack && hwe);
   cov_mem_write: cover property (mack && mwe);
   cov_mem_read: cover property (mack && !mwe);
   cov_irq: cover property (irq);
endmodule

// ### tb/test_sar_ring_table_dma.sv
`timescale 1ns/10ps
module test_sar_ring_table_dma;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic op_valid = 1'b0;
   sar_pkg::op_e op_code = sar_pkg::OP_TXQ;
   logic [sar_pkg::CH_W-1:0] op_chan = 15'h0;
   logic [31:0] op_addr = 32'h0;
   logic [31:0] prdata, res_addr, rd, got_addr;
   logic pready, pslverr, op_ready, res_valid, err;
   logic [15:0] res_size, got_size;
   int fail_count = 0;
   int tests_run = 0;
   sar_link_if lnk ();

   always #20 ref_clk = ~ref_clk;

   sar_dev u_sar_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .lnk(lnk),
      .op_valid(op_valid), .op_code(op_code), .op_chan(op_chan), .op_addr(op_addr),
      .op_ready(op_ready), .res_valid(res_valid), .res_addr(res_addr), .res_size(res_size));
   sar_host u_sar_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk(lnk));
   sar_link_props u_sar_link_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .hreq(lnk.hreq),
      .hwe(lnk.hwe), .haddr(lnk.haddr), .hwdata(lnk.hwdata), .hack(lnk.hack),
      .mreq(lnk.mreq), .mwe(lnk.mwe), .maddr(lnk.maddr), .mwdata(lnk.mwdata),
      .mack(lnk.mack), .irq(lnk.irq));

   // ****************************************
   // compare and report
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons=%0d mismatches=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************
   // apb master and link access helpers
   // ****************************************
   // request held until pready is seen, so slow answers are tolerated
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         fail_count++;
         conclude();
      end
   endtask

   // one device access: address, data, go, then poll busy and fetch read data
   task automatic dev(input logic wr, input logic [16:0] a, input logic [31:0] d);
      int n;
      apb(1'b1, sar_pkg::A_ADDR, {15'h0, a});
      apb(1'b1, sar_pkg::A_WDATA, d);
      apb(1'b1, sar_pkg::A_CMD, {30'h0, wr, 1'b1});
      for (n = 0; n < 20; n++) begin
         apb(1'b0, sar_pkg::A_CMD, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      apb(1'b0, sar_pkg::A_RDATA, 32'h0);
      if (n == 20) begin
         fail_count++;
         conclude();
      end
   endtask

   task automatic cmw(input logic [15:0] w, input logic [31:0] d);
      dev(1'b1, {1'b1, w}, d);
   endtask

   task automatic regw(input int i, input logic [31:0] d);
      dev(1'b1, 17'(i), d);
   endtask

   task automatic hmw(input logic [7:0] w, input logic [31:0] d);
      apb(1'b1, {2'h1, w, 2'h0}, d);
   endtask

   task automatic hmc(input logic [7:0] w, input logic [31:0] exp);
      apb(1'b0, {2'h1, w, 2'h0}, 32'h0);
      check(rd, exp);
   endtask

   task automatic irqc(input logic [31:0] exp);
      apb(1'b0, sar_pkg::A_STAT, 32'h0);
      check({16'h0, rd[31:16]}, exp);
   endtask

   // op held until taken, result captured in its one valid cycle
   task automatic op(input sar_pkg::op_e c, input logic [14:0] ch, input logic [31:0] a);
      int n;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_chan <= ch;
      op_addr <= a;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (op_ready === 1'b1) break;
      end
      op_valid <= 1'b0;
      if (n == 50) begin
         fail_count++;
         conclude();
      end
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (res_valid === 1'b1) break;
      end
      got_addr = res_addr;
      got_size = res_size;
      if (n == 50) begin
         fail_count++;
         conclude();
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // reset values of every register; status shows idle
      for (int i = 0; i < 16; i++) begin
         dev(1'b0, 17'(i), 32'h0);
         check(rd, (i inside {[2:5], 10}) ? 32'h100 : (i == 15) ? 32'hf : 32'(i == 1));
      end
      regw(14, 32'h1234);
      dev(1'b0, 17'd14, 32'h0);
      check(rd, 32'h1234);
      regw(13, 32'h55);
      dev(1'b0, 17'd13, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, err}, 32'h1);
      // segmentation ring of two slots wraps on the third fetch
      cmw(16'h1018, 32'h1);
      cmw(16'h1019, 32'h100);
      cmw(16'h101a, 32'h0);
      cmw(16'h1020, 32'h0);
      regw(10, 32'h2);
      hmw(8'd64, 32'ha000);
      hmw(8'd65, 32'hb000);
      for (int k = 0; k < 3; k++) begin
         op(sar_pkg::OP_TXQ, 15'd3, 32'h0);
         check(got_addr, (k == 1) ? 32'hb000 : 32'ha000);
      end
      dev(1'b0, 17'h1101a, 32'h0);
      check(rd, 32'h1);
      // interrupting tx completion ring of two slots, then masked, then plain ring
      regw(2, 32'h2);
      regw(6, 32'h200);
      regw(7, 32'h280);
      irqc(32'h0);
      for (int k = 0; k < 3; k++) begin
         op(sar_pkg::OP_TXC, 15'd3, 32'h1000 * (k + 1));
         check(got_addr, 32'h1000 * (k + 1));
      end
      hmc(8'd128, 32'h3000);
      hmc(8'd129, 32'h2000);
      irqc(32'h3);
      regw(15, 32'he);
      op(sar_pkg::OP_TXC, 15'd3, 32'h4000);
      hmc(8'd129, 32'h4000);
      irqc(32'h3);
      regw(15, 32'hf);
      op(sar_pkg::OP_TXC, 15'd4, 32'h5000);
      hmc(8'd160, 32'h5000);
      irqc(32'h3);
      // rx completions through the pointer table; one-slot ring overwrites in place
      cmw(16'h3405, 32'h2000);
      cmw(16'h2000, 32'h1);
      cmw(16'h3408, 32'h2300);
      cmw(16'h2300, 32'h0);
      regw(4, 32'h1);
      regw(8, 32'h300);
      regw(9, 32'h340);
      hmw(8'd193, 32'h0);
      op(sar_pkg::OP_RXC, 15'd5, 32'h6000);
      op(sar_pkg::OP_RXC, 15'd5, 32'h6100);
      hmc(8'd192, 32'h6100);
      hmc(8'd193, 32'h0);
      irqc(32'h5);
      op(sar_pkg::OP_RXC, 15'd8, 32'h7000);
      hmc(8'd208, 32'h7000);
      irqc(32'h5);
      // free buffers from ring 7; upper bits of word 6 must be ignored
      cmw(16'h3406, 32'h2100);
      cmw(16'h2100, 32'h0);
      cmw(16'h2106, 32'hff07);
      cmw(16'h301c, 32'h380);
      cmw(16'h301d, 32'h600);
      cmw(16'h301e, 32'h2);
      cmw(16'h301f, 32'h0);
      hmw(8'd224, 32'h8000);
      hmw(8'd225, 32'h9000);
      for (int k = 0; k < 3; k++) begin
         op(sar_pkg::OP_RXB, 15'd6, 32'h0);
         check(got_addr, (k == 1) ? 32'h9000 : 32'h8000);
         check({16'h0, got_size}, 32'h600);
      end
      // free buffer from a per-channel fifo
      cmw(16'h3407, 32'h2200);
      cmw(16'h2200, 32'h2);
      cmw(16'h2206, 32'h3f0);
      regw(11, 32'h800);
      hmw(8'd252, 32'ha000);
      op(sar_pkg::OP_RXB, 15'd7, 32'h0);
      check(got_addr, 32'ha000);
      check({16'h0, got_size}, 32'h800);
      // clock enable low freezes the sequencer, so a standing request is not taken
      ce <= 1'b0;
      op_valid <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check({30'h0, lnk.mreq, op_ready}, 32'h1);
      op_valid <= 1'b0;
      ce <= 1'b1;
      conclude();
   end
endmodule
